// [rtl/rtd_pkg.sv]
/*
  Constants for the resistive touch digitizer controller: register map,
  control fields, reset values and timing counts.
  Assumes a single 10 MHz reference clock and an external converter and
  plate drivers that the controller steers.
*/
// What this block does
// - Interrupt output goes high; any read clears it
// - Read during interrupt generation leaves interrupt high
// - Touch output low when touched, else high
// - Access only with chip select plus strobe
// - Eight byte registers on three address lines
// - Rate register sets periodic conversion rate
// - Period is 35716 plus 4096 times count
// - Reset clears registers zero, one and six
// - Reset loads rate register with count 32
// - Control register zero means powered down
// - Interrupt cleared by read or power-down write
// - Untouched: Y plate high, X plate low
// - X plate high is touch; converts if enabled
// - No bounce check until X and Y done
// - Pen lift seen only after conversion completes
// - Convert, store, interrupt while touched; then idle
// - Twelve-bit coordinates; address 4 holds Y low
// - Wait 1 ms after interrupt before next cycle
// - Touch and interrupt outputs need no conversion activity
// - Full screen voltage maps to code 4095
package rtd_pkg;

  // ==========================================================================
  // Register map
  localparam logic [2:0] ADDR_X_LOW = 3'h0;
  localparam logic [2:0] ADDR_X_HIGH = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_SPARE = 3'h3;
  localparam logic [2:0] ADDR_Y_LOW = 3'h4;
  localparam logic [2:0] ADDR_Y_HIGH = 3'h5;
  localparam logic [2:0] ADDR_CONTROL = 3'h6;
  localparam logic [2:0] ADDR_RATE = 3'h7;

  // ==========================================================================
  // Field layout
  localparam int CTRL_PERIODIC_BIT = 0;
  localparam int CTRL_TOUCH_IRQ_BIT = 1;
  localparam int CTRL_CONV_IRQ_BIT = 2;
  localparam int STAT_TOUCH_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int COORD_W = 12;
  localparam logic [11:0] FULL_SCALE_CODE = 12'h0_FFF;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_COORD = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h20;
  localparam logic [7:0] POWER_DOWN_VALUE = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int PERIOD_BASE_CYCLES = 35716;
  localparam int PERIOD_RATE_STEP = 4096;
  localparam int SETTLE_TIME_US = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_US * (CLK_HZ / 1_000_000));
  localparam int IRQ_GEN_TIME_NS = 100;
  localparam int IRQ_GEN_CYCLES_RAW = (IRQ_GEN_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int IRQ_GEN_CYCLES = (IRQ_GEN_CYCLES_RAW < 1) ? 1 : IRQ_GEN_CYCLES_RAW;
  localparam int TIMER_W = 21;

  typedef enum logic [2:0] {
    ST_OFF = 3'b100,
    ST_IDLE = 3'b000,
    ST_CONV_X = 3'b001,
    ST_CONV_Y = 3'b011,
    ST_SETTLE = 3'b010,
    ST_WAIT = 3'b110
  } rtd_state_e;

endpackage : rtd_pkg

// [rtl/rtd_timer.sv]
/*
  Down counter that flags completion a set number of cycles after a load.
  Assumes load is a one-cycle pulse from the controller.
*/
`timescale 1ns/1ps
module rtd_timer #(
  parameter int WIDTH = 21
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic done
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic done;
  } rtd_timer_s;

  rtd_timer_s s_q;
  rtd_timer_s s_d;

  if (WIDTH < 2) begin : g_bad_width
    $error("rtd_timer: WIDTH too small");
  end

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = load_value;
      s_d.done = 1'b0;
    end else if (s_q.cnt > WIDTH'(1)) begin
      s_d.cnt = s_q.cnt - WIDTH'(1);
    end else begin
      s_d.cnt = '0;
      s_d.done = 1'b1;
    end
  end

  // Idle timer reports done so a first conversion never waits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{cnt: '0, done: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;

endmodule : rtd_timer

// [rtl/rtd_edge.sv]
/*
  Registered start and end pulses of a level.
  Assumes the level is synchronous to ref_clk.
*/
`timescale 1ns/1ps
module rtd_edge (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic prev;
    logic rise;
    logic fall;
  } rtd_edge_s;

  rtd_edge_s s_q;
  rtd_edge_s s_d;

  always_comb begin
    s_d.prev = level;
    s_d.rise = level & ~s_q.prev;
    s_d.fall = ~level & s_q.prev;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise = s_q.rise;
  assign fall = s_q.fall;

endmodule : rtd_edge

// [rtl/rtd_touch_ctrl.sv]
/*
  Touch digitizer controller: host register port, plate drive, touch
  detection, periodic conversion sequencing and interrupt.
  Assumes an external converter that answers adc_start with adc_done and a
  12-bit result, and plate pins whose levels the pad ring resolves from the
  drive and enable outputs. Bus inputs are synchronous to ref_clk.
*/
`timescale 1ns/1ps
module rtd_touch_ctrl #(
  parameter int PERIOD_BASE = rtd_pkg::PERIOD_BASE_CYCLES,
  parameter int RATE_STEP = rtd_pkg::PERIOD_RATE_STEP,
  parameter int SETTLE_CYCLES = rtd_pkg::SETTLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_addr_bit2,
  input wire logic reg_addr_bit1,
  input wire logic reg_addr_bit0,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic irq,
  output logic touch_n,
  input wire logic x_touch_sense,
  output logic x_plate_high_out,
  output logic x_plate_high_oe,
  output logic x_plate_low_out,
  output logic x_plate_low_oe,
  output logic y_plate_high_out,
  output logic y_plate_high_oe,
  output logic y_plate_low_out,
  output logic y_plate_low_oe,
  output logic adc_start,
  output logic adc_sel_y,
  input wire logic adc_done,
  input wire logic [11:0] adc_data
);

  localparam int TW = rtd_pkg::TIMER_W;

  // ==========================================================================
  // Elaboration checks
  if (PERIOD_BASE + RATE_STEP * 255 >= (1 << TW)) begin : g_bad_period
    $error("rtd_touch_ctrl: conversion period does not fit the timer");
  end
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << TW)) begin : g_bad_settle
    $error("rtd_touch_ctrl: settle count out of range");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    rtd_pkg::rtd_state_e st;
    logic [11:0] x_coord;
    logic [11:0] y_coord;
    logic [11:0] x_hold;
    logic [7:0] control;
    logic [7:0] rate;
    logic touched;
    logic irq;
    logic [3:0] gen_cnt;
    logic gen_in_read;
    logic [7:0] dout;
    logic doe;
    logic touch_n;
    logic adc_start;
    logic adc_sel_y;
    logic [3:0] pdrv;
    logic [3:0] poe;
  } rtd_ctrl_s;

  rtd_ctrl_s s_q;
  rtd_ctrl_s s_d;

  logic [2:0] addr;
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic rd_end;
  logic wr_start;
  logic per_load;
  logic per_done;
  logic set_load;
  logic set_done;
  logic [TW-1:0] per_value;
  logic powered;
  logic periodic_en;
  logic irq_event;
  logic [7:0] rd_mux;

  assign addr = {reg_addr_bit2, reg_addr_bit1, reg_addr_bit0};
  assign rd_act = ~cs_n & ~rd_n;
  assign wr_act = ~cs_n & ~wr_n;
  assign powered = (s_q.control != rtd_pkg::POWER_DOWN_VALUE);
  assign periodic_en = s_q.control[rtd_pkg::CTRL_PERIODIC_BIT];

  // Period measured from one conversion start to the next
  // One less than the period: the start pulse registered after done adds a cycle
  assign per_value = TW'(PERIOD_BASE) + TW'(RATE_STEP) * TW'(s_q.rate) - TW'(1);

  // ==========================================================================
  // Helpers
  rtd_edge u_rd_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(rd_act),
    .rise(rd_start),
    .fall(rd_end)
  );

  rtd_edge u_wr_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(wr_act),
    .rise(wr_start),
    .fall()
  );

  rtd_timer #(
    .WIDTH(TW)
  ) u_period (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(per_load),
    .load_value(per_value),
    .done(per_done)
  );

  rtd_timer #(
    .WIDTH(TW)
  ) u_settle (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(set_load),
    .load_value(TW'(SETTLE_CYCLES)),
    .done(set_done)
  );

  // ==========================================================================
  // Read data
  always_comb begin
    unique case (addr)
      rtd_pkg::ADDR_X_LOW: rd_mux = s_q.x_coord[7:0];
      rtd_pkg::ADDR_X_HIGH: rd_mux = {4'h0, s_q.x_coord[11:8]};
      rtd_pkg::ADDR_STATUS: begin
        rd_mux = 8'h00;
        rd_mux[rtd_pkg::STAT_TOUCH_BIT] = s_q.touched;
        rd_mux[rtd_pkg::STAT_BUSY_BIT] = (s_q.st == rtd_pkg::ST_CONV_X) || (s_q.st == rtd_pkg::ST_CONV_Y);
      end
      rtd_pkg::ADDR_SPARE: rd_mux = 8'h00;
      rtd_pkg::ADDR_Y_LOW: rd_mux = s_q.y_coord[7:0];
      rtd_pkg::ADDR_Y_HIGH: rd_mux = {4'h0, s_q.y_coord[11:8]};
      rtd_pkg::ADDR_CONTROL: rd_mux = s_q.control;
      rtd_pkg::ADDR_RATE: rd_mux = s_q.rate;
    endcase
  end

  // ==========================================================================
  // Sequencer, registers and interrupt
  always_comb begin
    s_d = s_q;
    per_load = 1'b0;
    set_load = 1'b0;
    irq_event = 1'b0;
    s_d.adc_start = 1'b0;

    // Bus answer is registered, so it trails the strobes by one cycle
    s_d.doe = rd_act;
    s_d.dout = rd_act ? rd_mux : 8'h00;

    // Register writes; codes 0 to 8 are the host's to avoid
    if (wr_start) begin
      if (addr == rtd_pkg::ADDR_CONTROL) begin
        s_d.control = data_in;
      end else if (addr == rtd_pkg::ADDR_RATE) begin
        s_d.rate = data_in;
      end
    end

    unique case (s_q.st)
      rtd_pkg::ST_OFF: begin
        if (powered) begin
          s_d.st = rtd_pkg::ST_IDLE;
        end
      end
      rtd_pkg::ST_IDLE: begin
        // Touch sense is only trusted while the idle drive is applied
        if (x_touch_sense != s_q.touched) begin
          s_d.touched = x_touch_sense;
          irq_event = s_q.control[rtd_pkg::CTRL_TOUCH_IRQ_BIT];
        end
        if (x_touch_sense && periodic_en && per_done) begin
          s_d.st = rtd_pkg::ST_CONV_X;
          s_d.adc_start = 1'b1;
          s_d.adc_sel_y = 1'b0;
          per_load = 1'b1;
        end
      end
      rtd_pkg::ST_CONV_X: begin
        // No touch checks until both axes are in
        if (adc_done) begin
          s_d.x_hold = adc_data;
          s_d.st = rtd_pkg::ST_CONV_Y;
          s_d.adc_start = 1'b1;
          s_d.adc_sel_y = 1'b1;
        end
      end
      rtd_pkg::ST_CONV_Y: begin
        if (adc_done) begin
          // Converter output is ratiometric, 0 to full scale
          s_d.x_coord = s_q.x_hold & rtd_pkg::FULL_SCALE_CODE;
          s_d.y_coord = adc_data & rtd_pkg::FULL_SCALE_CODE;
          irq_event = s_q.control[rtd_pkg::CTRL_CONV_IRQ_BIT];
          s_d.st = rtd_pkg::ST_SETTLE;
          set_load = 1'b1;
        end
      end
      rtd_pkg::ST_SETTLE: begin
        s_d.st = rtd_pkg::ST_WAIT;
      end
      rtd_pkg::ST_WAIT: begin
        // Pen lift or bounce becomes visible only here, after the point
        if (set_done && per_done) begin
          if (x_touch_sense != s_q.touched) begin
            s_d.touched = x_touch_sense;
            irq_event = s_q.control[rtd_pkg::CTRL_TOUCH_IRQ_BIT];
          end
          if (x_touch_sense && periodic_en) begin
            s_d.st = rtd_pkg::ST_CONV_X;
            s_d.adc_start = 1'b1;
            s_d.adc_sel_y = 1'b0;
            per_load = 1'b1;
          end else begin
            s_d.st = rtd_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        s_d.st = rtd_pkg::ST_OFF;
      end
    endcase

    // Power-down aborts any conversion and quiets the sequencer
    if (!powered) begin
      s_d.st = rtd_pkg::ST_OFF;
      s_d.touched = x_touch_sense;
      irq_event = 1'b0;
    end

    // Plate drive: idle bias unless converting an axis
    unique case (s_d.st)
      rtd_pkg::ST_CONV_X: begin
        s_d.pdrv = 4'b0010;
        s_d.poe = 4'b0011;
      end
      rtd_pkg::ST_CONV_Y: begin
        s_d.pdrv = 4'b1000;
        s_d.poe = 4'b1100;
      end
      default: begin
        // Y plate high, X plate low so a press lifts the X plate
        s_d.pdrv = 4'b1000;
        s_d.poe = 4'b1001;
      end
    endcase

    // Touch output follows the sense level even when powered down
    s_d.touch_n = ~((s_q.st == rtd_pkg::ST_CONV_X || s_q.st == rtd_pkg::ST_CONV_Y) ?
                    s_q.touched : x_touch_sense);

    // Interrupt generation window
    if (irq_event) begin
      s_d.gen_cnt = 4'(rtd_pkg::IRQ_GEN_CYCLES);
    end else if (s_q.gen_cnt != 4'h0) begin
      s_d.gen_cnt = s_q.gen_cnt - 4'h1;
    end
    if (rd_start) begin
      s_d.gen_in_read = (s_q.gen_cnt != 4'h0) || irq_event;
    end else if (rd_act && (irq_event || s_q.gen_cnt != 4'h0)) begin
      s_d.gen_in_read = 1'b1;
    end

    // A read ends the interrupt unless one was being raised meanwhile
    if (rd_end && !s_q.gen_in_read && s_q.gen_cnt == 4'h0) begin
      s_d.irq = 1'b0;
    end
    if (wr_start && addr == rtd_pkg::ADDR_CONTROL && data_in == rtd_pkg::POWER_DOWN_VALUE) begin
      s_d.irq = 1'b0;
    end
    // Set wins over any clear in the same cycle
    if (irq_event) begin
      s_d.irq = 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.st <= rtd_pkg::ST_OFF;
      s_q.x_coord <= {4'h0, rtd_pkg::RST_COORD};
      s_q.y_coord <= {4'h0, rtd_pkg::RST_COORD};
      s_q.x_hold <= 12'h000;
      s_q.control <= rtd_pkg::RST_CONTROL;
      s_q.rate <= rtd_pkg::RST_RATE;
      s_q.touched <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.gen_cnt <= 4'h0;
      s_q.gen_in_read <= 1'b0;
      s_q.dout <= 8'h00;
      s_q.doe <= 1'b0;
      s_q.touch_n <= 1'b1;
      s_q.adc_start <= 1'b0;
      s_q.adc_sel_y <= 1'b0;
      s_q.pdrv <= 4'b1000;
      s_q.poe <= 4'b1001;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign data_out = s_q.dout;
  assign data_oe = s_q.doe;
  assign irq = s_q.irq;
  assign touch_n = s_q.touch_n;
  assign adc_start = s_q.adc_start;
  assign adc_sel_y = s_q.adc_sel_y;
  assign x_plate_low_out = s_q.pdrv[0];
  assign x_plate_high_out = s_q.pdrv[1];
  assign y_plate_low_out = s_q.pdrv[2];
  assign y_plate_high_out = s_q.pdrv[3];
  assign x_plate_low_oe = s_q.poe[0];
  assign x_plate_high_oe = s_q.poe[1];
  assign y_plate_low_oe = s_q.poe[2];
  assign y_plate_high_oe = s_q.poe[3];

endmodule : rtd_touch_ctrl

// [tb/rtd_touch_ctrl_assertions.sv]
/*
  Port-level checker for rtd_touch_ctrl, bound into every instance.
  Assumes the converter answers only a conversion that was started.
*/
`timescale 1ns/1ps
module rtd_touch_ctrl_assertions #(
  parameter int PERIOD_BASE = 35716,
  parameter int RATE_STEP = 4096,
  parameter int SETTLE_CYCLES = 10000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic data_oe,
  input wire logic irq,
  input wire logic touch_n,
  input wire logic x_touch_sense,
  input wire logic x_plate_high_out,
  input wire logic x_plate_high_oe,
  input wire logic x_plate_low_out,
  input wire logic x_plate_low_oe,
  input wire logic y_plate_high_out,
  input wire logic y_plate_high_oe,
  input wire logic y_plate_low_oe,
  input wire logic adc_start,
  input wire logic adc_sel_y,
  input wire logic adc_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ====
  // Cycles since the last stored point and the last X start
  int unsigned since_y_q;
  int unsigned since_x_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_y_q <= 32'h4000_0000;
      since_x_q <= 32'h4000_0000;
    end else begin
      since_y_q <= (adc_done && adc_sel_y) ? 32'h0000_0000 : since_y_q + 1;
      since_x_q <= (adc_start && !adc_sel_y) ? 32'h0000_0000 : since_x_q + 1;
    end
  end

  // ====
  // Bus
  chk_oe_read: assert property (data_oe |-> (!$past(cs_n) && !$past(rd_n)) ||
    (!$past(cs_n, 2) && !$past(rd_n, 2)) || (!$past(cs_n, 3) && !$past(rd_n, 3))) else $error("bus driven outside read");
  chk_read_drives: assert property ((!cs_n && !rd_n)[*4] |-> data_oe) else $error("read not answered");
  chk_no_select: assert property (cs_n[*4] |-> !data_oe) else $error("bus driven while deselected");
  chk_read_clear: assert property ((!cs_n && !rd_n && !adc_done && $stable(x_touch_sense))[*4] ##1
    (rd_n && !adc_done && $stable(x_touch_sense))[*4] |-> !irq) else $error("read left irq set");

  // ====
  // Screen and conversions
  chk_touch_show: assert property ($fell(touch_n) |-> $past(x_touch_sense) || $past(x_touch_sense, 2))
    else $error("touch shown without touch");
  chk_idle_plates: assert property (touch_n |-> y_plate_high_oe && y_plate_high_out && x_plate_low_oe &&
    !x_plate_low_out) else $error("idle plate drive wrong");
  chk_x_drive: assert property (adc_start && !adc_sel_y |-> x_plate_high_oe && x_plate_high_out &&
    x_plate_low_oe && !x_plate_low_out && !y_plate_high_oe && !y_plate_low_oe) else $error("X drive wrong");
  chk_x_hold: assert property (adc_start && !adc_sel_y |=> !adc_start until adc_done)
    else $error("restart before X done");
  chk_y_follows: assert property (adc_done && !adc_sel_y |=> adc_start && adc_sel_y)
    else $error("Y not started after X");
  chk_store_irq: assert property (adc_done && adc_sel_y |-> ##[1:2] irq) else $error("no irq after point");
  chk_settle_gap: assert property (adc_start && !adc_sel_y |-> since_y_q >= SETTLE_CYCLES)
    else $error("start inside settle time");
  chk_rate_floor: assert property (adc_start && !adc_sel_y |-> since_x_q + 1 >= PERIOD_BASE + 9 * RATE_STEP)
    else $error("period below minimum");
endmodule : rtd_touch_ctrl_assertions

bind rtd_touch_ctrl rtd_touch_ctrl_assertions #(.PERIOD_BASE(PERIOD_BASE), .RATE_STEP(RATE_STEP),
  .SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
  .data_oe(data_oe), .irq(irq), .touch_n(touch_n), .x_touch_sense(x_touch_sense),
  .x_plate_high_out(x_plate_high_out), .x_plate_high_oe(x_plate_high_oe), .x_plate_low_out(x_plate_low_out),
  .x_plate_low_oe(x_plate_low_oe), .y_plate_high_out(y_plate_high_out), .y_plate_high_oe(y_plate_high_oe),
  .y_plate_low_oe(y_plate_low_oe), .adc_start(adc_start), .adc_sel_y(adc_sel_y), .adc_done(adc_done));

// [tb/rtd_adc_model.sv]
/*
  Converter model: answers each start after a random delay with the
  coordinate of the selected axis.
  Assumes starts are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
module rtd_adc_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic adc_start,
  input wire logic adc_sel_y,
  input wire logic [11:0] x_val,
  input wire logic [11:0] y_val,
  output logic adc_done,
  output logic [11:0] adc_data
);
  integer seed = 32'h5bb5_440d;
  int wait_q;
  logic busy_q;
  logic sel_q;

  // Result lines toggle outside the done cycle so a stale sample is caught
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      sel_q <= 1'b0;
      wait_q <= 0;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start) begin
        busy_q <= 1'b1;
        sel_q <= adc_sel_y;
        wait_q <= 1 + $unsigned($random(seed)) % 6;
      end else if (busy_q && wait_q > 1) begin
        wait_q <= wait_q - 1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= sel_q ? y_val : x_val;
      end
    end
  end
endmodule : rtd_adc_model

// [tb/tb_top.sv]
/*
  Self-checking bench for rtd_touch_ctrl with a converter model.
  Assumes shortened period and settle counts set below.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int BASE = 50;
  localparam int STEP = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] data_in = 8'h00;
  logic x_touch_sense = 1'b0;
  logic [11:0] x_val = 12'hFFF;
  logic [11:0] y_val = 12'h800;
  logic [7:0] data_out;
  logic [11:0] adc_data;
  logic data_oe, irq, touch_n, adc_start, adc_sel_y, adc_done;
  logic xho, xhoe, xlo, xloe, yho, yhoe, ylo, yloe;
  integer seed = 32'h5bb5_440d;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int starts = 0;
  int y_done = 0;
  int t_x = 0;
  int per_x = 0;
  logic oe_seen = 1'b0;
  logic [7:0] exp_q[$];

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  rtd_touch_ctrl #(.PERIOD_BASE(BASE), .RATE_STEP(STEP), .SETTLE_CYCLES(20)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .reg_addr_bit2(addr[2]), .reg_addr_bit1(addr[1]), .reg_addr_bit0(addr[0]), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .irq(irq), .touch_n(touch_n), .x_touch_sense(x_touch_sense),
    .x_plate_high_out(xho), .x_plate_high_oe(xhoe), .x_plate_low_out(xlo), .x_plate_low_oe(xloe),
    .y_plate_high_out(yho), .y_plate_high_oe(yhoe), .y_plate_low_out(ylo), .y_plate_low_oe(yloe),
    .adc_start(adc_start), .adc_sel_y(adc_sel_y), .adc_done(adc_done), .adc_data(adc_data));

  rtd_adc_model adc_u (.ref_clk(ref_clk), .rst_n(rst_n), .adc_start(adc_start), .adc_sel_y(adc_sel_y),
    .x_val(x_val), .y_val(y_val), .adc_done(adc_done), .adc_data(adc_data));

  // ====
  // Observers
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (adc_start && !adc_sel_y) begin
      starts <= starts + 1;
      t_x <= cyc;
      per_x <= cyc - t_x;
    end
    if (adc_done && adc_sel_y) begin
      y_done <= y_done + 1;
    end
  end

  always @(negedge ref_clk) begin
    if (data_oe === 1'b1 && !oe_seen) begin
      check(16'(data_out), 16'(exp_q.pop_front()));
    end
    oe_seen <= (data_oe === 1'b1);
  end

  // ====
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Strobe held four cycles, then a three-cycle gap
  task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic rd, input logic cs);
    addr = a;
    data_in = d;
    cs_n = cs;
    rd_n = !rd;
    wr_n = rd;
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask : bus

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 8'h00, 1'b1, 1'b0);
  endtask : rd

  task automatic point(input int p, input int per);
    logic [11:0] x;
    logic [11:0] y;
    int n;
    x = x_val;
    y = y_val;
    n = y_done;
    while (y_done == n) @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
    check(16'(touch_n), 16'(!x_touch_sense));
    check(16'(irq), 16'h0001);
    rd(3'h0, x[7:0]);
    rd(3'h1, {4'h0, x[11:8]});
    rd(3'h4, y[7:0]);
    rd(3'h5, {4'h0, y[11:8]});
    check(16'(irq), 16'h0000);
    if (p == 2) check(16'(per_x), 16'(per));
    x_val = 12'($random(seed));
    y_val = 12'($random(seed));
  endtask : point

  task automatic complete_run();
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Ceiling well above the at most roughly 1500 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end

  // ====
  // Sequence
  initial begin
    logic [7:0] rate;
    int n;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    rd(3'h6, 8'h00);
    rd(3'h7, 8'h20);
    rd(3'h3, 8'h00);
    bus(3'h4, 8'hA5, 1'b0, 1'b0);
    bus(3'h7, 8'h33, 1'b0, 1'b1);
    rd(3'h4, 8'h00);
    rd(3'h7, 8'h20);
    check(16'({xhoe, xho, yloe, ylo, yhoe, yho, xloe, xlo}), 16'h000E);
    x_touch_sense = 1'b1;
    repeat (40) @(negedge ref_clk);
    check(16'(touch_n), 16'h0000);
    check(16'(starts), 16'h0000);
    check(16'(irq), 16'h0000);
    x_touch_sense = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(16'(touch_n), 16'h0001);
    bus(3'h6, 8'h07, 1'b0, 1'b0);
    for (int r = 0; r < 2; r++) begin
      rate = (r == 0) ? 8'h09 : 8'(9 + $unsigned($random(seed)) % 32);
      bus(3'h7, rate, 1'b0, 1'b0);
      x_touch_sense = 1'b1;
      for (int p = 0; p < 3; p++) point(p, BASE + STEP * rate);
    end
    // Lift the pen just after a conversion starts
    while (!(adc_start && !adc_sel_y)) @(posedge ref_clk);
    @(negedge ref_clk);
    x_touch_sense = 1'b0;
    @(negedge ref_clk);
    check(16'(touch_n), 16'h0000);
    point(0, 0);
    repeat (200) @(negedge ref_clk);
    n = starts;
    check(16'(touch_n), 16'h0001);
    check(16'(irq), 16'h0001);
    bus(3'h6, 8'h00, 1'b0, 1'b0);
    check(16'(irq), 16'h0000);
    bus(3'h6, 8'h07, 1'b0, 1'b0);
    repeat (200) @(negedge ref_clk);
    check(16'(irq), 16'h0000);
    check(16'(starts), 16'(n));
    check(16'({xhoe, xho, yloe, ylo, yhoe, yho, xloe, xlo}), 16'h000E);
    complete_run();
  end
endmodule : tb_top
